/* File: dv/gdpc_partner.sv */
`timescale 1ns/100ps
module gdpc_partner (
  input  wire logic mclk,     // System clock
  input  wire logic arst_n,   // Async reset
  input  wire logic src_run,  // Run the source
  input  wire logic gate_lvl, // Wanted gate level
  output logic      src_in,   // Source pulses
  output logic      gate_in   // Gate level
);
  // Source rests low between runs, one rise per two cycles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      src_in  <= 1'b0;
      gate_in <= 1'b0;
    end else begin
      src_in  <= src_run ? ~src_in : 1'b0;
      gate_in <= gate_lvl;
    end
  end
endmodule

/* File: dv/test_gdpc_top.sv */
`timescale 1ns/100ps
module test_gdpc_top
  import gdpc_pkg::*;
;
  logic             mclk, arst_n, src_run, gate_lvl, src_in, gate_in;
  logic             mode_edge, arm_cmd, load_cmd, disarm_cmd, term_q, tog, armed_q, pulse_q;
  logic [CNT_W-1:0] load_val, hold_val, count_q;
  int               errors = 0;
  int               checks_done = 0;

  gdpc_partner u_far (.mclk(mclk), .arst_n(arst_n), .src_run(src_run), .gate_lvl(gate_lvl),
                      .src_in(src_in), .gate_in(gate_in));
  gdpc_top u_dut (.mclk(mclk), .arst_n(arst_n), .src_in(src_in), .gate_in(gate_in),
                  .mode_edge(mode_edge), .arm_cmd(arm_cmd), .disarm_cmd(disarm_cmd),
                  .load_cmd(load_cmd), .load_val(load_val), .hold_val(hold_val),
                  .count_q(count_q), .terminal_count_q(term_q), .out_toggle_q(tog),
                  .armed_q(armed_q), .pulse_q(pulse_q));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic test_done();
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic arm(input logic md);
    @(posedge mclk);
    mode_edge <= md;
    arm_cmd   <= 1'b1;
    @(posedge mclk);
    arm_cmd   <= 1'b0;
  endtask

  // Bounded wait, so a stuck phase shows as a mismatch
  task automatic wait_pulse(input logic lvl);
    int n;
    n = 0;
    while (pulse_q !== lvl && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk_bit(pulse_q, lvl);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic test_level();
    @(posedge mclk);
    load_val <= 16'h0003;
    hold_val <= 16'h0002;
    load_cmd <= 1'b1;
    gate_lvl <= 1'b1;
    src_run  <= 1'b1;
    @(posedge mclk);
    load_cmd <= 1'b0;
    run(8);
    gate_lvl <= 1'b0;
    @(negedge mclk);
    chk(count_q, 16'h0003);
    run(2);
    arm(MODE_LEVEL);
    run(10);
    @(negedge mclk);
    chk(count_q, 16'h0003);
    @(posedge mclk);
    gate_lvl <= 1'b1;
    wait_pulse(1'b1);
    chk(count_q, 16'h0002);
    chk_bit(tog, 1'b1);
    chk_bit(term_q, 1'b1);
    @(posedge mclk);
    gate_lvl <= 1'b0;
    run(12);
    @(negedge mclk);
    chk_bit(pulse_q & armed_q, 1'b1);
    chk(count_q, 16'h0001);
    @(posedge mclk);
    gate_lvl <= 1'b1;
    wait_pulse(1'b0);
    chk(count_q, 16'h0003);
    chk_bit(armed_q, 1'b0);
    chk_bit(tog, 1'b0);
    chk_bit(term_q, 1'b1);
  endtask

  task automatic test_edge();
    @(posedge mclk);
    gate_lvl <= 1'b0;
    run(2);
    gate_lvl <= 1'b1;
    run(4);
    gate_lvl <= 1'b0;
    run(2);
    arm(MODE_EDGE);
    run(8);
    @(negedge mclk);
    chk(count_q, 16'h0003);
    chk_bit(armed_q, 1'b1);
    @(posedge mclk);
    gate_lvl <= 1'b1;
    run(3);
    gate_lvl <= 1'b0;
    wait_pulse(1'b1);
    chk(count_q, 16'h0002);
    @(posedge mclk);
    gate_lvl <= 1'b1;
    wait_pulse(1'b0);
    chk(count_q, 16'h0003);
    chk_bit(armed_q, 1'b0);
    chk_bit(term_q, 1'b1);
  endtask

  // Load refused and disarm taken while armed, then no counting
  task automatic test_disarm();
    @(posedge mclk);
    gate_lvl <= 1'b0;
    arm(MODE_LEVEL);
    @(negedge mclk);
    chk_bit(armed_q, 1'b1);
    @(posedge mclk);
    load_val <= 16'h0005;
    load_cmd <= 1'b1;
    @(posedge mclk);
    load_cmd   <= 1'b0;
    disarm_cmd <= 1'b1;
    @(posedge mclk);
    disarm_cmd <= 1'b0;
    @(negedge mclk);
    chk(count_q, 16'h0003);
    chk_bit(armed_q, 1'b0);
    @(posedge mclk);
    gate_lvl <= 1'b1;
    run(8);
    @(negedge mclk);
    chk(count_q, 16'h0003);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #100000;
    errors++;
    test_done();
  end

  initial begin
    arst_n    = 1'b0;
    src_run   = 1'b0;
    gate_lvl  = 1'b0;
    mode_edge = 1'b0;
    arm_cmd   = 1'b0;
    load_cmd  = 1'b0;
    disarm_cmd = 1'b0;
    load_val  = 16'h0000;
    hold_val  = 16'h0000;
    repeat (2) @(posedge mclk);
    chk(count_q, CNT_RST);
    arst_n <= 1'b1;
    test_level();
    test_edge();
    test_disarm();
    test_done();
  end
endmodule

/* File: src/gdpc_count.sv */
`timescale 1ns/100ps
module gdpc_count
  import gdpc_pkg::*;
(
  input  wire logic             mclk,     // System clock
  input  wire logic             arst_n,   // Async reset
  input  wire logic             load_en,  // Parallel load, wins over decrement
  input  wire logic [CNT_W-1:0] load_val, // Value to load
  input  wire logic             dec_en,   // Count one source edge
  output logic      [CNT_W-1:0] count_q   // Current count
);

  logic [CNT_W-1:0] count_d;

  assign count_d = load_en ? load_val :
                   dec_en  ? count_q - CNT_DEC :
                             count_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= CNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

/* File: src/gdpc_edge.sv */
`timescale 1ns/100ps
module gdpc_edge
  import gdpc_pkg::*;
(
  input  wire logic mclk,     // System clock
  input  wire logic arst_n,   // Async reset
  input  wire logic level_in, // Sampled level
  output logic      rise      // Active-going edge, one cycle
);

  logic prev_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= IDLE_LVL;
    end else begin
      prev_q <= level_in;
    end
  end

  assign rise = level_in & ~prev_q;

endmodule

/* File: src/gdpc_pkg.sv */
package gdpc_pkg;

  localparam int unsigned CNT_W = 16;

  // Counter values that steer reset, terminal count and the decrement step
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_DEC = 16'h0001;

  // Gating modes, sampled at arm
  localparam logic MODE_LEVEL = 1'b0;
  localparam logic MODE_EDGE  = 1'b1;

  localparam logic GATE_ACTIVE = 1'b1;
  localparam logic OUT_RST     = 1'b0;
  // Idle level of source and gate, so no false edge follows reset
  localparam logic IDLE_LVL    = 1'b0;

  typedef enum logic [1:0] {
    ST_DISARMED,
    ST_WAIT_TRIG,
    ST_DELAY,
    ST_PULSE
  } gdpc_state_t;

endpackage

/* File: src/gdpc_top.sv */
`timescale 1ns/100ps
// Summary of operation
// - Level mode counts only source edges seen while gate is active.
// - Level mode never counts unless the counter is armed.
// - Level mode reloads from hold value at the first terminal count.
// - Level mode reloads from load value and disarms at second terminal count.
// - Level mode inactive gate pauses both delay and pulse phases.
// - Edge mode armed counter waits for a gate edge before counting.
// - Edge mode ignores gate edges while disarmed.
// - Edge mode begins counting on first source edge after the trigger.
// - Edge mode disarms at the second terminal count.
// - Edge mode ignores gate levels and edges once triggered until done.
module gdpc_top
  import gdpc_pkg::*;
(
  input  wire logic             mclk,         // 10 MHz clock
  input  wire logic             arst_n,       // Async reset
  input  wire logic             src_in,       // Count source level
  input  wire logic             gate_in,      // Gate level, active high
  input  wire logic             mode_edge,    // 1 edge-triggered, 0 level-gated
  input  wire logic             arm_cmd,      // Arm pulse
  input  wire logic             disarm_cmd,   // Disarm pulse
  input  wire logic             load_cmd,     // Load counter from load value
  input  wire logic [CNT_W-1:0] load_val,     // Load register value
  input  wire logic [CNT_W-1:0] hold_val,     // Hold register value
  output logic      [CNT_W-1:0] count_q,      // Counter contents
  output logic                  terminal_count_q, // One-cycle terminal count
  output logic                  out_toggle_q, // Toggles on each terminal count
  output logic                  armed_q,      // Counter armed
  output logic                  pulse_q       // Second phase in progress
);

  ////////////////////////////////////////////////////////////////////////////
  gdpc_state_t state_q;
  gdpc_state_t state_d;
  logic        mode_q;
  logic        src_rise;
  logic        gate_rise;
  logic        running;
  logic        gate_ok;
  logic        cnt_en;
  logic        term_hit;
  logic        ld_en;
  logic [CNT_W-1:0] ld_val;

  gdpc_edge u_src_edge (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .level_in (src_in),
    .rise     (src_rise)
  );

  gdpc_edge u_gate_edge (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .level_in (gate_in),
    .rise     (gate_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign running = (state_q == ST_DELAY) || (state_q == ST_PULSE);
  // edge mode ignores gate once running
  assign gate_ok = (mode_q == MODE_EDGE) || (gate_in == GATE_ACTIVE);
  assign cnt_en   = src_rise & running & gate_ok;
  assign term_hit = cnt_en & (count_q == CNT_ONE);
  // hold value first, same in edge mode
  assign ld_en   = term_hit | (load_cmd & (state_q == ST_DISARMED));
  assign ld_val  = (term_hit && state_q == ST_DELAY) ? hold_val : load_val;

  gdpc_count u_count (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .load_en  (ld_en),
    .load_val (ld_val),
    .dec_en   (cnt_en),
    .count_q  (count_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_DISARMED: begin
        // gate edges have no effect here
        if (arm_cmd) begin
          state_d = (mode_edge == MODE_EDGE) ? ST_WAIT_TRIG : ST_DELAY;
        end
      end
      ST_WAIT_TRIG: begin
        // wait for trigger, count from next source edge
        if (gate_rise) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (term_hit) begin
          state_d = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (term_hit) begin
          state_d = ST_DISARMED;
        end
      end
      default: begin
        state_d = ST_DISARMED;
      end
    endcase
    if (disarm_cmd) begin
      state_d = ST_DISARMED;
    end
  end

  // Mode is latched at arm so changes while armed cannot upset a cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_DISARMED;
      mode_q  <= MODE_LEVEL;
    end else begin
      state_q <= state_d;
      if (state_q == ST_DISARMED && arm_cmd) begin
        mode_q <= mode_edge;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      terminal_count_q <= OUT_RST;
      out_toggle_q     <= OUT_RST;
      armed_q          <= OUT_RST;
      pulse_q          <= OUT_RST;
    end else begin
      terminal_count_q <= term_hit;
      out_toggle_q     <= out_toggle_q ^ term_hit;
      armed_q          <= (state_d != ST_DISARMED);
      pulse_q          <= (state_d == ST_PULSE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  gated_skip_a: assert property (
    running && mode_q == MODE_LEVEL && src_rise && gate_in != GATE_ACTIVE
    |=> $stable(count_q))
    else $error("source edge counted while gate inactive");

  idle_hold_a: assert property (
    state_q == ST_DISARMED && !load_cmd |=> $stable(count_q))
    else $error("count changed while disarmed");

  hold_reload_a: assert property (
    state_q == ST_DELAY && term_hit && !disarm_cmd
    |=> count_q == $past(hold_val) && state_q == ST_PULSE && terminal_count_q)
    else $error("first terminal count did not reload hold value");

  load_reload_a: assert property (
    state_q == ST_PULSE && term_hit
    |=> count_q == $past(load_val) && !armed_q && state_q == ST_DISARMED)
    else $error("second terminal count did not reload and disarm");

  gate_pause_a: assert property (
    running && mode_q == MODE_LEVEL && gate_in != GATE_ACTIVE && !disarm_cmd
    |=> $stable(state_q) && $stable(count_q))
    else $error("inactive gate did not pause phase");

  trig_wait_a: assert property (
    state_q == ST_WAIT_TRIG && !gate_rise && !disarm_cmd
    |=> state_q == ST_WAIT_TRIG && $stable(count_q))
    else $error("counting began without trigger edge");

  disarm_edge_a: assert property (
    state_q == ST_DISARMED && !arm_cmd |=> state_q == ST_DISARMED)
    else $error("disarmed counter left idle without arm");

  first_src_a: assert property (
    state_q == ST_WAIT_TRIG && gate_rise && !disarm_cmd
    ##1 (src_rise && !disarm_cmd && count_q != CNT_ONE)
    |=> count_q == $past(count_q) - CNT_DEC)
    else $error("first source edge after trigger not counted");

  edge_done_a: assert property (
    mode_q == MODE_EDGE && state_q == ST_PULSE && term_hit |=> state_q == ST_DISARMED)
    else $error("edge mode did not disarm at second terminal count");

  gate_ignore_a: assert property (
    mode_q == MODE_EDGE && running && src_rise && count_q != CNT_ONE
    |=> count_q == $past(count_q) - CNT_DEC)
    else $error("gate affected triggered edge-mode count");

  edge_reload_a: assert property (
    mode_q == MODE_EDGE && state_q == ST_DELAY && term_hit |=> count_q == $past(hold_val))
    else $error("edge mode first reload not from hold value");

  level_arm_a: assert property (
    state_q == ST_DISARMED && arm_cmd && !disarm_cmd && mode_edge == MODE_LEVEL
    |=> state_q == ST_DELAY && armed_q && !pulse_q)
    else $error("level mode arm did not start delay phase");

  edge_arm_a: assert property (
    state_q == ST_DISARMED && arm_cmd && !disarm_cmd && !load_cmd && mode_edge == MODE_EDGE
    |=> state_q == ST_WAIT_TRIG && armed_q && $stable(count_q))
    else $error("edge mode arm did not wait for trigger");

  gated_count_a: assert property (
    running && mode_q == MODE_LEVEL && src_rise && gate_in == GATE_ACTIVE && count_q != CNT_ONE
    |=> count_q == $past(count_q) - CNT_DEC)
    else $error("qualified source edge not counted");

  src_only_a: assert property (
    running && !src_rise && !disarm_cmd
    |=> $stable(count_q) && $stable(state_q))
    else $error("count moved without a source edge");

  idle_quiet_a: assert property (
    !running
    |-> !cnt_en && !term_hit)
    else $error("count enabled outside the count phases");

  trig_hold_a: assert property (
    state_q == ST_WAIT_TRIG && gate_rise && !disarm_cmd
    |=> state_q == ST_DELAY && $stable(count_q))
    else $error("source edge at the trigger was counted");

  early_edge_a: assert property (
    state_q == ST_DISARMED && gate_rise && arm_cmd && !disarm_cmd && mode_edge == MODE_EDGE
    |=> state_q == ST_WAIT_TRIG)
    else $error("gate edge before arm taken as trigger");

  edge_low_a: assert property (
    mode_q == MODE_EDGE && running && src_rise && gate_in != GATE_ACTIVE && count_q != CNT_ONE
    |=> count_q != $past(count_q))
    else $error("low gate paused triggered edge mode count");

  edge_retrig_a: assert property (
    mode_q == MODE_EDGE && running && gate_rise && !src_rise && !disarm_cmd
    |=> $stable(state_q) && $stable(count_q))
    else $error("gate edge retriggered a running count");

  edge_pulse_a: assert property (
    mode_q == MODE_EDGE && state_q == ST_PULSE && term_hit
    |=> count_q == $past(load_val))
    else $error("edge mode second reload not from load value");

  term_flag_a: assert property (
    term_hit
    |=> terminal_count_q && out_toggle_q != $past(out_toggle_q))
    else $error("terminal count not flagged or toggled");

  term_quiet_a: assert property (
    !term_hit
    |=> !terminal_count_q && $stable(out_toggle_q))
    else $error("terminal count flag without terminal count");

  pulse_flag_a: assert property (
    state_q == ST_DELAY && term_hit && !disarm_cmd
    |=> pulse_q && armed_q)
    else $error("pulse flag missing after first terminal count");

  gate_stop_a: assert property (
    running && mode_q == MODE_LEVEL && gate_in != GATE_ACTIVE
    |=> !terminal_count_q)
    else $error("terminal count while gate inactive");

  delay_stay_a: assert property (
    state_q == ST_DELAY && !term_hit && !disarm_cmd
    |=> state_q == ST_DELAY)
    else $error("delay phase left without terminal count");

  pulse_stay_a: assert property (
    state_q == ST_PULSE && !term_hit && !disarm_cmd
    |=> state_q == ST_PULSE && pulse_q)
    else $error("pulse phase left without terminal count");

  disarm_wins_a: assert property (
    disarm_cmd
    |=> state_q == ST_DISARMED && !armed_q && !pulse_q)
    else $error("disarm command did not stop the counter");

  load_refuse_a: assert property (
    running && load_cmd && !cnt_en
    |=> $stable(count_q))
    else $error("load taken while armed");

  wait_load_a: assert property (
    state_q == ST_WAIT_TRIG && load_cmd
    |=> $stable(count_q))
    else $error("load taken while waiting for trigger");

  armed_flag_a: assert property (
    state_q == ST_DISARMED && !arm_cmd
    |=> !armed_q && !pulse_q)
    else $error("armed flag raised while disarmed");

endmodule
